//--- fts_pkg.sv
// constants, types and reset state for the flow-through burst sram core
// Behaviour
// (R1) array of 131,072 words by 18 bits
// (R2) processor strobe with selects loads, starts read
// (R3) read data flows straight out, no register
// (R4) burst step ignored on processor strobe edge
// (R5) step low, strobes high advances burst address
// (R6) order pin high interleaved, low linear
// (R7) controller disables outputs before any write
// (R8) global write stores all 18 bits
// (R9) else gated byte lanes write their bytes
// (R10) byte lanes ignored on processor strobe edge
// (R11) sampled byte write turns outputs off
// (R12) byte write captures data into input register
// (R13) write with step low advances burst address
// (R14) controller keeps processor strobe high on controller start
// (R15) controller start samples write controls same edge
// (R16) master select blocks processor strobe only
// (R17) output enable gates drivers asynchronously
// (R18) three chip selects must all be active
// (R19) second select active high, third active low
// (R20) no lane asserted with gate low reads
// (R21) strobe loads address or deselects to standby
// (R22) snooze keeps data, ignores inputs, outputs off
// (R23) two-bit burst counter wraps within four words
// (R24) step high, no strobe holds burst address
package fts_pkg;

  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 18;
  localparam int LANE_W      = 9;
  localparam int LANES       = 2;
  localparam int BURST_W     = 2;
  localparam int SYNC_STAGES = 3;
  localparam int WORDS       = 131072;

  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

  typedef enum logic [1:0] {
    FTS_IDLE  = 2'b00,
    FTS_READ  = 2'b01,
    FTS_WRITE = 2'b10
  } fts_mode_e;

  typedef struct packed {
    logic master_select_n;
    logic select_high;
    logic select_low_n;
  } fts_sel_s;

  typedef struct packed {
    logic             global_write_n;
    logic             byte_write_gate_n;
    logic [LANES-1:0] byte_lane_write_n;
  } fts_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0]      addr;
    logic [BURST_W-1:0]     start;
    logic [BURST_W-1:0]     cnt;
    fts_mode_e              mode;
    logic [DATA_W-1:0]      din;
    logic [SYNC_STAGES-1:0] zz_sync;
    logic [SYNC_STAGES-1:0] lbo_sync;
    logic                   zz_lvl;
    logic                   lbo_lvl;
  } fts_state_s;

  // order pin idles high (interleaved), snooze idles low
  localparam fts_state_s ST_RESET = '{
    addr:     17'h00000,
    start:    2'h0,
    cnt:      2'h0,
    mode:     FTS_IDLE,
    din:      18'h00000,
    zz_sync:  3'h0,
    lbo_sync: 3'h7,
    zz_lvl:   1'h0,
    lbo_lvl:  1'h1
  };

endpackage

//--- fts_burst.sv
// two-bit burst address sequencer, linear or interleaved
`timescale 1ns/100ps
module fts_burst (
  // burst origin and running count
  input  wire logic [fts_pkg::BURST_W-1:0] start,
  input  wire logic [fts_pkg::BURST_W-1:0] cnt,
  input  wire logic                        linear,
  // next step
  output logic      [fts_pkg::BURST_W-1:0] next_cnt,
  output logic      [fts_pkg::BURST_W-1:0] next_lo
);

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  // the count wraps in two bits, so a burst never leaves its four-word block
  always_comb begin
    next_cnt = fts_pkg::BURST_W'(cnt + fts_pkg::BURST_ONE);                    // [R23]
    if (linear) begin
      next_lo = fts_pkg::BURST_W'(start + next_cnt);                           // [R23]
    end else begin
      next_lo = start ^ next_cnt;                                              // [R23]
    end
  end

endmodule

//--- fts_sram.sv
// flow-through burst sram core: strobes, burst counter, byte writes, array
`timescale 1ns/100ps
module fts_sram (
  // clock, reset, enable
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  // address and strobes
  input  wire logic [fts_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic                        processor_addr_strobe_n,
  input  wire logic                        controller_addr_strobe_n,
  input  wire logic                        burst_step_n,
  // chip selects and write controls
  input  wire fts_pkg::fts_sel_s           selects,
  input  wire fts_pkg::fts_wr_s            write_ctl,
  // asynchronous and static controls
  input  wire logic                        output_enable_n,
  input  wire logic                        snooze_request,
  input  wire logic                        linear_order_select_n,
  // data pins, split into in, out and enable
  input  wire logic [fts_pkg::DATA_W-1:0]  dq_in,
  output logic      [fts_pkg::DATA_W-1:0]  dq_out,
  output logic                             dq_oe,
  // status
  output logic                             snooze_active,
  output logic                             standby
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  fts_pkg::fts_state_s                   st_reg;
  fts_pkg::fts_state_s                   st_next;
  logic [fts_pkg::DATA_W-1:0]            mem [fts_pkg::WORDS];
  logic                                  sel_all;
  logic                                  processor_addr_strobe_n_take;
  logic                                  controller_addr_strobe_n_take;
  logic                                  strobes_idle;
  logic [fts_pkg::LANES-1:0]             lane_we;
  logic [fts_pkg::LANES-1:0]             wr_lanes;
  logic [fts_pkg::ADDR_W-1:0]            acc_addr;
  logic [fts_pkg::BURST_W-1:0]           nxt_cnt;
  logic [fts_pkg::BURST_W-1:0]           nxt_lo;

  // lanes that a write command enables; zero means the cycle reads
  function automatic logic [fts_pkg::LANES-1:0] lanes_of(input fts_pkg::fts_wr_s w);
    logic [fts_pkg::LANES-1:0] l;
    l = '0;
    if (!w.global_write_n) begin
      l = '1;                                                                  // [R8]
    end else if (!w.byte_write_gate_n) begin
      l = ~w.byte_lane_write_n;                                                // [R9] [R20]
    end
    return l;
  endfunction

  // --------------------------------------------------------------------------
  // strobe decode
  // --------------------------------------------------------------------------
  assign sel_all = !selects.master_select_n && selects.select_high &&
                   !selects.select_low_n;                                      // [R18] [R19]
  // the master select only gates the processor strobe
  assign processor_addr_strobe_n_take    = !processor_addr_strobe_n && !selects.master_select_n;  // [R16]
  assign controller_addr_strobe_n_take    = !controller_addr_strobe_n && !processor_addr_strobe_n_take;               // [R14]
  assign strobes_idle = processor_addr_strobe_n && controller_addr_strobe_n;
  assign wr_lanes     = lanes_of(write_ctl);

  fts_burst u_burst (
    .start    (st_reg.start),
    .cnt      (st_reg.cnt),
    .linear   (!st_reg.lbo_lvl),
    .next_cnt (nxt_cnt),
    .next_lo  (nxt_lo)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    lane_we  = '0;
    acc_addr = st_reg.addr;
    // asynchronous pins: three stages, level taken when the last two agree
    st_next.zz_sync  = {st_reg.zz_sync[1:0], snooze_request};
    st_next.lbo_sync = {st_reg.lbo_sync[1:0], linear_order_select_n};
    if (st_reg.zz_sync[1] == st_reg.zz_sync[2]) begin
      st_next.zz_lvl = st_reg.zz_sync[2];
    end
    if (st_reg.lbo_sync[1] == st_reg.lbo_sync[2]) begin
      st_next.lbo_lvl = st_reg.lbo_sync[2];                                    // [R6]
    end
    if (st_reg.zz_lvl) begin
      // pending cycle is dropped; array contents stay untouched
      st_next.mode = fts_pkg::FTS_IDLE;                                        // [R22]
    end else if (processor_addr_strobe_n_take) begin
      // write controls and burst step are not looked at on this edge
      if (sel_all) begin
        st_next.addr  = addr_in;                                               // [R2] [R4] [R10]
        st_next.start = addr_in[fts_pkg::BURST_W-1:0];
        st_next.cnt   = '0;
        st_next.mode  = fts_pkg::FTS_READ;                                     // [R2]
      end else begin
        st_next.mode  = fts_pkg::FTS_IDLE;                                     // [R21]
      end
    end else if (controller_addr_strobe_n_take) begin
      if (sel_all) begin
        acc_addr      = addr_in;
        lane_we       = wr_lanes;                                              // [R15]
        st_next.addr  = addr_in;
        st_next.start = addr_in[fts_pkg::BURST_W-1:0];
        st_next.cnt   = '0;
        st_next.mode  = (|wr_lanes) ? fts_pkg::FTS_WRITE : fts_pkg::FTS_READ;  // [R15]
      end else begin
        st_next.mode  = fts_pkg::FTS_IDLE;                                     // [R21]
      end
    end else begin
      case (st_reg.mode)
        fts_pkg::FTS_READ,
        fts_pkg::FTS_WRITE: begin
          if (strobes_idle && !burst_step_n) begin
            // step first: this edge's access already uses the next address
            acc_addr = {st_reg.addr[fts_pkg::ADDR_W-1:fts_pkg::BURST_W], nxt_lo};  // [R5] [R13] [R23]
            st_next.addr = acc_addr;
            st_next.cnt  = nxt_cnt;
          end
          // with the step high the same word is accessed again
          lane_we      = wr_lanes;                                             // [R24] [R9]
          st_next.mode = (|wr_lanes) ? fts_pkg::FTS_WRITE : fts_pkg::FTS_READ; // [R11] [R20]
        end
        default: begin
          st_next.mode = fts_pkg::FTS_IDLE;
        end
      endcase
    end
    if (|lane_we) begin
      st_next.din = dq_in;                                                     // [R12]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= fts_pkg::ST_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // array
  // --------------------------------------------------------------------------
  // no reset on the array: contents survive reset and snooze alike
  always_ff @(posedge mclk) begin
    if (clk_en && reset_n) begin
      for (int i = 0; i < fts_pkg::LANES; i++) begin
        if (lane_we[i]) begin
          mem[acc_addr][i*fts_pkg::LANE_W +: fts_pkg::LANE_W] <=
            dq_in[i*fts_pkg::LANE_W +: fts_pkg::LANE_W];                       // [R1] [R8] [R9]
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // flow-through: the registered address selects the word within the cycle
  assign dq_out = mem[st_reg.addr];                                            // [R3]
  // raw snooze pin also gates, so drivers drop before the synchroniser settles
  assign dq_oe  = (st_reg.mode == fts_pkg::FTS_READ) && !output_enable_n &&
                  !st_reg.zz_lvl && !snooze_request;                           // [R17] [R11] [R22]
  assign snooze_active = st_reg.zz_lvl;
  assign standby       = (st_reg.mode == fts_pkg::FTS_IDLE);                   // [R21]

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  logic run;
  assign run = clk_en && !st_reg.zz_lvl;

  a_processor_addr_strobe_n_load_read: assert property (@(posedge mclk) disable iff (!reset_n)  // [R2]
    (run && processor_addr_strobe_n_take && sel_all) |=>
      (st_reg.addr == $past(addr_in)) && (st_reg.mode == fts_pkg::FTS_READ))
    else $error("processor strobe did not load address and start a read");

  a_processor_addr_strobe_n_no_write: assert property (@(posedge mclk) disable iff (!reset_n)  // [R10]
    (run && processor_addr_strobe_n_take && sel_all && !write_ctl.global_write_n) |=>
      (st_reg.mode != fts_pkg::FTS_WRITE) && (st_reg.din == $past(st_reg.din)))
    else $error("write taken on processor strobe edge");

  a_flow_through: assert property (@(posedge mclk) disable iff (!reset_n)  // [R3]
    (run && processor_addr_strobe_n_take && sel_all) |=> (dq_out == mem[$past(addr_in)]))
    else $error("read word not at output in the cycle after load");

  a_master_blocks: assert property (@(posedge mclk) disable iff (!reset_n)  // [R16]
    (run && !processor_addr_strobe_n && selects.master_select_n &&
     controller_addr_strobe_n && burst_step_n) |=>
      (st_reg.addr == $past(st_reg.addr)) && (st_reg.cnt == $past(st_reg.cnt)))
    else $error("processor strobe acted with master select inactive");

  a_controller_addr_strobe_n_write: assert property (@(posedge mclk) disable iff (!reset_n)  // [R15]
    (run && controller_addr_strobe_n_take && sel_all && !write_ctl.global_write_n) |=>
      (st_reg.mode == fts_pkg::FTS_WRITE) && (st_reg.din == $past(dq_in)) &&
      (mem[$past(addr_in)] == $past(dq_in)))
    else $error("controller strobe write not taken on its own edge");

  a_byte_gate_read: assert property (@(posedge mclk) disable iff (!reset_n)  // [R20]
    (run && !processor_addr_strobe_n_take && !controller_addr_strobe_n_take && (st_reg.mode != fts_pkg::FTS_IDLE) &&
     write_ctl.global_write_n && write_ctl.byte_write_gate_n) |=>
      (st_reg.mode == fts_pkg::FTS_READ))
    else $error("gate high with global write high did not read");

  a_deselect: assert property (@(posedge mclk) disable iff (!reset_n)  // [R21]
    (run && (processor_addr_strobe_n_take || controller_addr_strobe_n_take) && !sel_all) |=> standby && !dq_oe)
    else $error("strobe with inactive select did not deselect");

  a_linear_step: assert property (@(posedge mclk) disable iff (!reset_n)  // [R5]
    (run && !processor_addr_strobe_n_take && !controller_addr_strobe_n_take && strobes_idle && !burst_step_n &&
     (st_reg.mode != fts_pkg::FTS_IDLE) && !st_reg.lbo_lvl) |=>
      (st_reg.addr[1:0] == 2'($past(st_reg.addr[1:0]) + fts_pkg::BURST_ONE)))
    else $error("linear burst did not add one");

  a_interleave_step: assert property (@(posedge mclk) disable iff (!reset_n)  // [R23]
    (run && !processor_addr_strobe_n_take && !controller_addr_strobe_n_take && strobes_idle && !burst_step_n &&
     (st_reg.mode != fts_pkg::FTS_IDLE) && st_reg.lbo_lvl) |=>
      (st_reg.addr[1:0] == ($past(st_reg.start) ^ 2'($past(st_reg.cnt) + fts_pkg::BURST_ONE))))
    else $error("interleaved burst address wrong");

  a_hold_burst: assert property (@(posedge mclk) disable iff (!reset_n)  // [R24]
    (run && strobes_idle && burst_step_n) |=> (st_reg.addr == $past(st_reg.addr)))
    else $error("burst address moved with step high");

  a_write_off: assert property (@(posedge mclk) disable iff (!reset_n)  // [R11]
    (st_reg.mode == fts_pkg::FTS_WRITE) |-> !dq_oe)
    else $error("outputs driven during a write");

  a_oe_async: assert property (@(posedge mclk) disable iff (!reset_n)  // [R17]
    output_enable_n |-> !dq_oe)
    else $error("outputs driven with output enable high");

  a_snooze_off: assert property (@(posedge mclk) disable iff (!reset_n)  // [R22]
    (clk_en && st_reg.zz_lvl) |=> standby && !dq_oe && (st_reg.addr == $past(st_reg.addr)))
    else $error("snooze did not deselect and freeze");

  c_read_burst: cover property (@(posedge mclk) disable iff (!reset_n)
    (run && processor_addr_strobe_n_take && sel_all) ##1 (run && strobes_idle && !burst_step_n)[*3]);

  c_controller_addr_strobe_n_write: cover property (@(posedge mclk) disable iff (!reset_n)
    (run && controller_addr_strobe_n_take && sel_all && (|wr_lanes)));

  c_byte_write: cover property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.mode == fts_pkg::FTS_READ) ##1 (run && write_ctl.global_write_n &&
     !write_ctl.byte_write_gate_n && (wr_lanes == 2'h1)));

  c_snooze: cover property (@(posedge mclk) disable iff (!reset_n)
    !snooze_active ##1 snooze_active);

endmodule

//--- fts_host_model.sv
// far-side controller model: data bus resolution and output enable discipline
`timescale 1ns/100ps
module fts_host_model (
  // clock
  input  wire logic                       mclk,
  // controller side
  input  wire logic                       host_en,
  input  wire logic                       oe_req_n,
  input  wire logic [fts_pkg::DATA_W-1:0] host_dq,
  // device side
  input  wire logic [fts_pkg::DATA_W-1:0] dut_dq,
  input  wire logic                       dut_oe,
  output logic      [fts_pkg::DATA_W-1:0] dq_in,
  output logic                            output_enable_n
);
  // ----------------------------------------
  // bus resolution
  // ----------------------------------------
  logic [fts_pkg::DATA_W-1:0] last_dq;

  always_ff @(posedge mclk) begin
    last_dq <= dq_in;
  end

  // buffers are switched off whenever the controller drives the bus
  assign output_enable_n = oe_req_n | host_en;

  // a released bus shows the inverse of its last level, never a stale value
  always_comb begin
    if (dut_oe) begin
      dq_in = dut_dq;
    end else if (host_en) begin
      dq_in = host_dq;
    end else begin
      dq_in = ~last_dq;
    end
  end
endmodule

//--- flow_through_burst_sync_sram_tb.sv
// self-checking bench for the flow-through burst sram core
`timescale 1ns/100ps
module flow_through_burst_sync_sram_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic        proc;
    logic        ctrl;
    logic        step;
    logic        drv;
    logic [2:0]  sel;
    logic [3:0]  wr;
    logic [16:0] addr;
    logic [17:0] din;
    logic [17:0] edq;
    logic        eoe;
    logic        esb;
  } fts_row_s;

  localparam int NROWS = 21;
  localparam fts_row_s IDLE = '{1'h1, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00000, 18'h00000, 18'h00000, 1'h0, 1'h0};

  logic                       mclk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       proc_n = 1'b1;
  logic                       ctrl_n = 1'b1;
  logic                       step_n = 1'b1;
  logic                       host_en = 1'b0;
  logic                       oe_req_n = 1'b0;
  logic                       snooze = 1'b0;
  logic                       linear_n = 1'b1;
  logic                       clk_en = 1'b1;
  logic [16:0]                addr = 17'h00000;
  logic [17:0]                host_dq = 18'h00000;
  fts_pkg::fts_sel_s          sel = 3'h2;
  fts_pkg::fts_wr_s           wr = 4'hF;
  logic [17:0]                dq_in;
  logic [17:0]                dq_out;
  logic                       dq_oe;
  logic                       oe_n;
  logic                       snooze_active;
  logic                       standby;
  int                         n_errors = 0;
  int                         tests_run = 0;
  int                         cycles = 0;
  fts_row_s                   rows [NROWS];

  always #12.5 mclk = ~mclk;

  fts_sram i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .addr_in(addr),
    .processor_addr_strobe_n(proc_n), .controller_addr_strobe_n(ctrl_n), .burst_step_n(step_n),
    .selects(sel), .write_ctl(wr), .output_enable_n(oe_n), .snooze_request(snooze),
    .linear_order_select_n(linear_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .snooze_active(snooze_active), .standby(standby));

  fts_host_model i_host (.mclk(mclk), .host_en(host_en), .oe_req_n(oe_req_n), .host_dq(host_dq),
    .dut_dq(dq_out), .dut_oe(dq_oe), .dq_in(dq_in), .output_enable_n(oe_n));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // drive at a falling edge, the rising edge in between samples it
  task automatic drive(input fts_row_s r);
    proc_n = r.proc;
    ctrl_n = r.ctrl;
    step_n = r.step;
    host_en = r.drv;
    sel = fts_pkg::fts_sel_s'(r.sel);
    wr = fts_pkg::fts_wr_s'(r.wr);
    addr = r.addr;
    host_dq = r.din;
    @(negedge mclk);
  endtask

  // cycle limit covers the whole sequence with ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    // controller starts keep the processor strobe high
    rows = '{
      '{1'h1, 1'h0, 1'h1, 1'h1, 3'h2, 4'h7, 17'h00004, 18'h2AAAA, 18'h00000, 1'h0, 1'h0},
      '{1'h1, 1'h1, 1'h0, 1'h1, 3'h2, 4'h7, 17'h00000, 18'h15555, 18'h00000, 1'h0, 1'h0},
      '{1'h0, 1'h1, 1'h0, 1'h0, 3'h2, 4'h7, 17'h00004, 18'h3FFFF, 18'h2AAAA, 1'h1, 1'h0},
      '{1'h1, 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 17'h00000, 18'h00000, 18'h15555, 1'h1, 1'h0},
      '{1'h1, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00000, 18'h00000, 18'h15555, 1'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00005, 18'h00000, 18'h15555, 1'h1, 1'h0},
      '{1'h1, 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 17'h00000, 18'h00000, 18'h2AAAA, 1'h1, 1'h0},
      '{1'h1, 1'h0, 1'h1, 1'h1, 3'h2, 4'h7, 17'h00006, 18'h00000, 18'h00000, 1'h0, 1'h0},
      '{1'h1, 1'h0, 1'h1, 1'h1, 3'h2, 4'hA, 17'h00006, 18'h3FFFF, 18'h00000, 1'h0, 1'h0},
      '{1'h1, 1'h0, 1'h1, 1'h0, 3'h2, 4'hC, 17'h00006, 18'h00000, 18'h001FF, 1'h1, 1'h0},
      '{1'h1, 1'h0, 1'h1, 1'h0, 3'h2, 4'hB, 17'h00006, 18'h00000, 18'h001FF, 1'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00004, 18'h00000, 18'h2AAAA, 1'h1, 1'h0},
      '{1'h1, 1'h1, 1'h1, 1'h1, 3'h2, 4'h8, 17'h00000, 18'h12345, 18'h00000, 1'h0, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00004, 18'h00000, 18'h12345, 1'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h6, 4'hF, 17'h00005, 18'h00000, 18'h12345, 1'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h0, 4'hF, 17'h00005, 18'h00000, 18'h00000, 1'h0, 1'h1},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00005, 18'h00000, 18'h15555, 1'h1, 1'h0},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h3, 4'hF, 17'h00005, 18'h00000, 18'h00000, 1'h0, 1'h1},
      '{1'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00005, 18'h00000, 18'h15555, 1'h1, 1'h0},
      '{1'h1, 1'h0, 1'h1, 1'h0, 3'h6, 4'hF, 17'h00005, 18'h00000, 18'h00000, 1'h0, 1'h1},
      '{1'h1, 1'h0, 1'h1, 1'h0, 3'h2, 4'hF, 17'h00005, 18'h00000, 18'h15555, 1'h1, 1'h0}
    };
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    check(18'(standby), 18'h00001);
    check(18'(dq_oe), 18'h00000);
    check(18'(snooze_active), 18'h00000);
    for (int i = 0; i < NROWS; i++) begin
      drive(rows[i]);
      check(18'(standby), 18'(rows[i].esb));
      check(18'(dq_oe), 18'(rows[i].eoe));
      if (rows[i].eoe) begin
        check(dq_out, rows[i].edq);
      end
    end
    // output enable acts between edges
    #5 oe_req_n = 1'b1;
    #1 check(18'(dq_oe), 18'h00000);
    oe_req_n = 1'b0;
    #1 check(18'(dq_oe), 18'h00001);
    // linear order: 5 then 6, where interleaved gave 4
    @(negedge mclk);
    linear_n = 1'b0;
    repeat (5) drive(IDLE);
    drive(rows[5]);
    drive(rows[3]);
    check(dq_out, 18'h001FF);
    // snooze: outputs off at once, write attempt ignored, data kept
    snooze = 1'b1;
    #1 check(18'(dq_oe), 18'h00000);
    repeat (5) drive(IDLE);
    check(18'(snooze_active), 18'h00001);
    check(18'(standby), 18'h00001);
    drive('{1'h1, 1'h0, 1'h1, 1'h1, 3'h2, 4'h7, 17'h00005, 18'h00000, 18'h00000, 1'h0, 1'h0});
    snooze = 1'b0;
    repeat (5) drive(IDLE);
    drive(rows[5]);
    check(dq_out, 18'h15555);
    check(18'(dq_oe), 18'h00001);
    // clock enable low: a burst step must not move the address
    clk_en = 1'b0;
    drive(rows[3]);
    check(dq_out, 18'h15555);
    clk_en = 1'b1;
    drive(IDLE);
    check(dq_out, 18'h15555);
    test_done();
  end
endmodule
